// ### design/sdi_core.v
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "sdi_regs.vh"
// Functional notes
// - on-fly flag clears only by host writing one; a same-cycle set wins.
// - while engine runs only summary status is reachable by the host.
// - scsi-pending and dma-pending summary bits, may both be set.
// - reading scsi status lo/hi reports and clears scsi conditions.
// - fatal scsi while receiving drains dma fifo before raising interrupt.
// - clear dma fifo at test bit 2, clear scsi fifo at bit 1.
// - reading dma status reports and clears dma conditions.
// - dma status bit 7 fifo-empty is status only, never clears.
// - dma interrupts flush no fifo; host clears or flushes afterwards.
// - two scsi enable registers and one dma enable register mask.
// - control bit 1 masks pin; clearing it asserts pin for enabled status already set.
// - all dma interrupts fatal; fatal always stops engine.
// - enabling a non-fatal interrupt makes it fatal.
// - initiator non-fatal set; target adds attention-asserted.
// - on-fly interrupt is non-fatal, engine keeps running.
// - masked non-fatal sets status only, no pending, no pin.
// - masked fatal stops engine, sets status and pending, no pin.
// - clearing an enable after pin asserted does not deassert it, except for a non-fatal scsi condition made fatal only by that enable; setting the pin mask does.
// - while pending, new events stack in hidden copy, moved when cleared.
// - after clear, pin off at least three clocks, then reload.
// - masked non-fatal does not start stacking.
// - scsi interrupts held while dma fifo has data.
module sdi_core #(
    parameter GAP = `SDI_GAP_CLKS
) (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire [`SDI_ADDR_W-1:0] addr,
    input  wire [7:0]             wdata,
    input  wire                   wr,
    input  wire                   rd,
    output reg  [7:0]             rdata,
    input  wire [7:0]             scsi_ev_lo,
    input  wire [7:0]             scsi_ev_hi,
    input  wire [6:0]             dma_ev,
    input  wire                   fly_ev,
    input  wire                   rx_dir,
    input  wire                   dma_fifo_empty_pin,
    input  wire                   engine_stop_ack,
    output reg                    flush_dma_fifo,
    output reg                    clear_dma_fifo,
    output reg                    clear_scsi_fifo,
    output reg                    engine_run,
    output reg                    irq_n
);
    reg  [7:0] sen_lo_q;
    reg  [7:0] sen_hi_q;
    reg  [7:0] den_q;
    reg  [7:0] dctl_q;
    reg  [7:0] ct3_q;
    reg  [7:0] st3_q;
    reg        target_q;
    reg        fly_q;
    reg        irq_q;
    reg        start_q;
    // scsi events parked while the dma fifo holds data, dma events while it drains
    reg  [7:0] held_lo_q;
    reg  [7:0] held_hi_q;
    reg  [6:0] dheld_q;
    reg  [1:0] gap_q;
    reg        drain_q;
    wire       fifo_empty;
    wire [7:0] slo;
    wire [7:0] shi;
    wire [7:0] shlo;
    wire [7:0] shhi;
    wire [7:0] dvis;
    wire [7:0] dhid;
    // empty flag arrives from the fifo domain edge
    sdi_sync2 #(.W(1)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (dma_fifo_empty_pin),
        .q     (fifo_empty)
    );
    // non-fatal sets per mode
    wire [7:0] nf_lo = (8'h01 << `SDI_SL_CMP) | (8'h01 << `SDI_SL_SEL) |
                       (8'h01 << `SDI_SL_RSL) |
                       (target_q ? (8'h01 << `SDI_SL_MA) : 8'h00);
    wire [7:0] nf_hi = (8'h01 << `SDI_SH_HTH) | (8'h01 << `SDI_SH_GEN);
    // fatal when not in non-fatal set or enabled
    wire [7:0] fat_lo = ~nf_lo | sen_lo_q;
    wire [7:0] fat_hi = ~nf_hi | sen_hi_q;
    wire scsi_int_pending = |(slo & fat_lo) | |(shi & fat_hi);
    wire dma_int_pending = |dvis[6:0];
    wire pend = scsi_int_pending | dma_int_pending;
    wire sel_rd = rd && (!engine_run || addr == `SDI_OFF_INTERRUPT_SUMMARY_STATUS);
    wire sel_wr = wr && (!engine_run || addr == `SDI_OFF_INTERRUPT_SUMMARY_STATUS);
    wire rd_slo = sel_rd && addr == `SDI_OFF_SSTAT_LO;
    wire rd_shi = sel_rd && addr == `SDI_OFF_SSTAT_HI;
    wire rd_ds  = sel_rd && addr == `SDI_OFF_DMA_INT_STATUS;
    wire any_clr = (rd_slo || rd_shi || rd_ds) && pend;
    wire hid_any = |shlo | |shhi | |dhid;
    // scsi events held off while the dma fifo holds data
    wire post_ok = fifo_empty;
    wire [7:0] ev_lo = post_ok ? (scsi_ev_lo | held_lo_q) : 8'h00;
    wire [7:0] ev_hi = post_ok ? (scsi_ev_hi | held_hi_q) : 8'h00;
    // fatal while receiving waits for drain before dma posting
    wire [6:0] ev_d = (drain_q && !fifo_empty) ? 7'h00
                      : (dma_ev | dheld_q);
    wire load = gap_q == 2'd1;
    wire stack_en = pend || gap_q != 2'd0;
    sdi_stack #(.W(8)) u_slo (
        .clk(clk), .rst_n(rst_n), .ev(ev_lo), .stack_en(stack_en),
        .rd_clr(rd_slo), .load(load), .vis(slo), .hid(shlo)
    );
    sdi_stack #(.W(8)) u_shi (
        .clk(clk), .rst_n(rst_n), .ev(ev_hi), .stack_en(stack_en),
        .rd_clr(rd_shi), .load(load), .vis(shi), .hid(shhi)
    );
    sdi_stack #(.W(8)) u_ds (
        .clk(clk), .rst_n(rst_n), .ev({1'b0, ev_d}), .stack_en(stack_en),
        .rd_clr(rd_ds), .load(load), .vis(dvis), .hid(dhid)
    );
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sen_lo_q <= `SDI_RST_ENABLE;
            sen_hi_q <= `SDI_RST_ENABLE;
            den_q    <= `SDI_RST_ENABLE;
            dctl_q   <= `SDI_RST_CTRL;
            ct3_q    <= `SDI_RST_CTRL;
            st3_q    <= `SDI_RST_CTRL;
            target_q <= 1'b0;
            start_q  <= 1'b0;
            fly_q    <= 1'b0;
            held_lo_q <= 8'h00;
            held_hi_q <= 8'h00;
            dheld_q  <= 7'h00;
            drain_q  <= 1'b0;
            gap_q    <= 2'd0;
            irq_q    <= 1'b0;
            engine_run <= 1'b0;
            rdata    <= 8'h00;
            irq_n    <= 1'b1;
            flush_dma_fifo  <= 1'b0;
            clear_dma_fifo  <= 1'b0;
            clear_scsi_fifo <= 1'b0;
        end else begin
            // events seen while held stay until the fifo empties
            held_lo_q <= post_ok ? 8'h00 : (held_lo_q | scsi_ev_lo);
            held_hi_q <= post_ok ? 8'h00 : (held_hi_q | scsi_ev_hi);
            dheld_q <= (drain_q && !fifo_empty) ? (dheld_q | dma_ev)
                       : 7'h00;
            // fatal scsi while receiving: drain first
            if ((|(scsi_ev_lo & fat_lo) || |(scsi_ev_hi & fat_hi)) &&
                rx_dir && !fifo_empty)
                drain_q <= 1'b1;
            else if (fifo_empty)
                drain_q <= 1'b0;
            flush_dma_fifo <= (drain_q && !fifo_empty) |
                              ct3_q[`SDI_CT3_FLUSH];
            clear_dma_fifo  <= ct3_q[`SDI_CT3_CLEAR];
            clear_scsi_fifo <= st3_q[`SDI_ST3_CLEAR];
            // one-shot controls self clear
            ct3_q <= ct3_q & ~((8'h01 << `SDI_CT3_CLEAR) |
                               (8'h01 << `SDI_CT3_FLUSH));
            st3_q <= st3_q & ~(8'h01 << `SDI_ST3_CLEAR);
            start_q <= 1'b0;
            // set wins over the host's write-one clear
            if (fly_ev)
                fly_q <= 1'b1;
            else if (sel_wr && addr == `SDI_OFF_INTERRUPT_SUMMARY_STATUS &&
                     wdata[`SDI_IS_INT_ON_FLY_FLAG])
                fly_q <= 1'b0;
            if (sel_wr && addr != `SDI_OFF_INTERRUPT_SUMMARY_STATUS) begin
                if (addr == `SDI_OFF_SEN_LO)
                    sen_lo_q <= wdata;
                else if (addr == `SDI_OFF_SEN_HI)
                    sen_hi_q <= wdata;
                else if (addr == `SDI_OFF_DEN)
                    den_q <= wdata;
                else if (addr == `SDI_OFF_DCTL)
                    dctl_q <= wdata;
                else if (addr == `SDI_OFF_CHIP_TEST_REG_THREE)
                    ct3_q <= wdata;
                else if (addr == `SDI_OFF_SCSI_TEST_REG_THREE)
                    st3_q <= wdata;
                else if (addr == `SDI_OFF_MODE) begin
                    target_q <= wdata[`SDI_MODE_TARGET];
                    start_q  <= wdata[`SDI_MODE_START];
                end
            end
            // any pending fatal stops the engine
            if (pend || engine_stop_ack)
                engine_run <= 1'b0;
            else if (start_q)
                engine_run <= 1'b1;
            // gap counter after first level clears
            if (any_clr && hid_any)
                gap_q <= GAP[1:0];
            else if (gap_q != 2'd0)
                gap_q <= gap_q - 2'd1;
            // pin level; an asserted pin holds while anything is pending or on-fly is set, the pin mask or the gap counter drops it
            if (gap_q != 2'd0 || (any_clr && hid_any))
                irq_q <= 1'b0;
            else if (dctl_q[`SDI_DC_PIN_MASK])
                irq_q <= 1'b0;
            else if (irq_q)
                irq_q <= pend | fly_q;
            else
                irq_q <= (|(slo & sen_lo_q)) | (|(shi & sen_hi_q)) |
                         (|(dvis[6:0] & den_q[6:0])) | fly_q;
            irq_n <= ~irq_q;
            rdata <= 8'h00;
            if (sel_rd) begin
                if (addr == `SDI_OFF_INTERRUPT_SUMMARY_STATUS)
                    rdata <= {4'h0, engine_run, fly_q, scsi_int_pending, dma_int_pending};
                else if (addr == `SDI_OFF_SSTAT_LO)
                    rdata <= slo;
                else if (addr == `SDI_OFF_SSTAT_HI)
                    rdata <= shi;
                else if (addr == `SDI_OFF_DMA_INT_STATUS)
                    rdata <= {fifo_empty, dvis[6:0]};
                else if (addr == `SDI_OFF_SEN_LO)
                    rdata <= sen_lo_q;
                else if (addr == `SDI_OFF_SEN_HI)
                    rdata <= sen_hi_q;
                else if (addr == `SDI_OFF_DEN)
                    rdata <= den_q;
                else if (addr == `SDI_OFF_DCTL)
                    rdata <= dctl_q;
                else if (addr == `SDI_OFF_MODE)
                    rdata <= {7'h00, target_q};
            end
        end
    end
endmodule

// ### design/sdi_regs.vh
`ifndef SDI_REGS_VH
`define SDI_REGS_VH
// register offsets (byte addresses on the plain register port)
`define SDI_ADDR_W          8
`define SDI_OFF_INTERRUPT_SUMMARY_STATUS       8'h00
`define SDI_OFF_SSTAT_LO    8'h04
`define SDI_OFF_SSTAT_HI    8'h08
`define SDI_OFF_DMA_INT_STATUS       8'h0c
`define SDI_OFF_SEN_LO      8'h10
`define SDI_OFF_SEN_HI      8'h14
`define SDI_OFF_DEN         8'h18
`define SDI_OFF_DCTL        8'h1c
`define SDI_OFF_CHIP_TEST_REG_THREE      8'h20
`define SDI_OFF_SCSI_TEST_REG_THREE      8'h24
`define SDI_OFF_MODE        8'h28
// summary status fields
`define SDI_IS_DIP          0
`define SDI_IS_SIP          1
`define SDI_IS_INT_ON_FLY_FLAG         2
`define SDI_IS_RUN          3
// scsi status lo fields
`define SDI_SL_MA           0
`define SDI_SL_CMP          1
`define SDI_SL_SEL          2
`define SDI_SL_RSL          3
// scsi status hi fields
`define SDI_SH_HTH          0
`define SDI_SH_GEN          1
// dma status field, status only
`define SDI_DS_FIFO_EMPTY   7
// control fields
`define SDI_DC_PIN_MASK     1
`define SDI_CT3_FLUSH       3
`define SDI_CT3_CLEAR       2
`define SDI_ST3_CLEAR       1
`define SDI_MODE_TARGET     0
`define SDI_MODE_START      1
// timing
`define SDI_CLK_MHZ         50
`define SDI_GAP_CLKS        3
// reset values
`define SDI_RST_ENABLE      8'h00
`define SDI_RST_CTRL        8'h00
`endif

// ### design/sdi_sync2.v
`timescale 1ns/1ps
module sdi_sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] out_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            out_q  <= {W{1'b0}};
        end else begin
            meta_q <= d;
            out_q  <= meta_q;
        end
    end
    assign q = out_q;
endmodule

// ### design/sdi_stack.v
`timescale 1ns/1ps
// two-level status holder for one 8-bit interrupt status register
module sdi_stack #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] ev,
    input  wire         stack_en,
    input  wire         rd_clr,
    input  wire         load,
    output wire [W-1:0] vis,
    output wire [W-1:0] hid
);
    reg [W-1:0] vis_q;
    reg [W-1:0] hid_q;
    reg [W-1:0] vis_d;
    reg [W-1:0] hid_d;
    always @* begin
        vis_d = vis_q;
        hid_d = hid_q;
        if (rd_clr)
            vis_d = {W{1'b0}};
        if (load) begin
            vis_d = vis_d | hid_q;
            hid_d = {W{1'b0}};
        end
        // new events go behind a pending level, else straight in
        if (stack_en && !rd_clr)
            hid_d = hid_d | ev;
        else
            vis_d = vis_d | ev;
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vis_q <= {W{1'b0}};
            hid_q <= {W{1'b0}};
        end else begin
            vis_q <= vis_d;
            hid_q <= hid_d;
        end
    end
    assign vis = vis_q;
    assign hid = hid_q;
endmodule

// ### tb/sdi_fifo_model.sv
`timescale 1ns/1ps
// dma fifo stand-in: fill makes it non-empty, clear or flush drains it
module sdi_fifo_model (
    input  wire clk,
    input  wire rst_n,
    input  wire fill,
    input  wire clear_dma_fifo,
    input  wire flush_dma_fifo,
    output reg  empty
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            empty <= 1'b1;
        end else if (clear_dma_fifo || flush_dma_fifo) begin
            empty <= 1'b1;
        end else if (fill) begin
            empty <= 1'b0;
        end
    end
endmodule

// ### tb/sdi_props.sv
`timescale 1ns/1ps
`include "sdi_regs.vh"
module sdi_props (
    input wire       clk,
    input wire       rst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire [7:0] scsi_ev_lo,
    input wire [7:0] scsi_ev_hi,
    input wire [6:0] dma_ev,
    input wire       fly_ev,
    input wire       engine_stop_ack,
    input wire       flush_dma_fifo,
    input wire       clear_dma_fifo,
    input wire       clear_scsi_fifo,
    input wire       engine_run,
    input wire       irq_n
);
    reg pmask_q;
    // shadow of the pin mask, taken only while the engine is stopped
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pmask_q <= 1'b0;
        end else if (wr && !engine_run && addr == `SDI_OFF_DCTL) begin
            pmask_q <= wdata[1];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence quiet;
        dma_ev == 7'h00 && scsi_ev_lo == 8'h00 && scsi_ev_hi == 8'h00
            && !engine_stop_ack;
    endsequence
    sequence clr_dma_wr;
        wr && !engine_run && addr == `SDI_OFF_CHIP_TEST_REG_THREE && wdata[2];
    endsequence
    a_read_refused: assert property ($past(rd && engine_run && addr != 8'h00)
        |-> rdata == 8'h00) else $error("register read while running");
    a_pin_masked: assert property (pmask_q [*4] |-> irq_n)
        else $error("pin asserted while masked");
    a_gap_min: assert property ($rose(irq_n) |-> irq_n [*3])
        else $error("pin gap too short");
    a_dma_fatal: assert property (engine_run && dma_ev != 7'h00
        |-> ##[1:8] !engine_run) else $error("dma event left engine on");
    a_fly_runs: assert property (engine_run && fly_ev ##0 quiet
        ##1 quiet [*3] |-> engine_run) else $error("on-fly stopped engine");
    a_dma_no_flush: assert property (dma_ev != 7'h00 && !wr
        |=> !flush_dma_fifo && !clear_dma_fifo) else $error("fifo touched");
    a_clr_dma: assert property (clr_dma_wr |-> ##[1:2] clear_dma_fifo)
        else $error("dma fifo clear missing");
    a_clr_scsi: assert property (wr && !engine_run
        && addr == `SDI_OFF_SCSI_TEST_REG_THREE && wdata[1] |-> ##[1:2] clear_scsi_fifo)
        else $error("scsi fifo clear missing");
endmodule
bind sdi_core sdi_props u_props (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scsi_ev_lo(scsi_ev_lo), .scsi_ev_hi(scsi_ev_hi),
    .dma_ev(dma_ev), .fly_ev(fly_ev), .engine_stop_ack(engine_stop_ack),
    .flush_dma_fifo(flush_dma_fifo), .clear_dma_fifo(clear_dma_fifo),
    .clear_scsi_fifo(clear_scsi_fifo), .engine_run(engine_run),
    .irq_n(irq_n));

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "sdi_regs.vh"
module testbench;
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg  [7:0] lo = 8'h00;
    reg  [6:0] dev = 7'h00;
    reg        fly = 1'b0;
    reg        ack = 1'b0;
    reg        fill = 1'b0;
    reg        rx = 1'b0;
    wire [7:0] rdata;
    wire       fe, fl, cd, cs, run, irq_n;
    integer    err_count = 0;
    integer    samples_checked = 0;
    always #10 clk = ~clk;
    sdi_core uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .scsi_ev_lo(lo), .scsi_ev_hi(8'h00),
        .dma_ev(dev), .fly_ev(fly), .rx_dir(rx), .dma_fifo_empty_pin(fe),
        .engine_stop_ack(ack), .flush_dma_fifo(fl), .clear_dma_fifo(cd),
        .clear_scsi_fifo(cs), .engine_run(run), .irq_n(irq_n));
    sdi_fifo_model fifo (.clk(clk), .rst_n(rst_n), .fill(fill),
        .clear_dma_fifo(cd), .flush_dma_fifo(fl), .empty(fe));
    task give_verdict;
        begin
            $display("checked %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // run and irq_n, settled at the falling edge; m picks what matters
    task fl2(input logic [1:0] e, input logic [1:0] m);
        begin
            @(negedge clk);
            chk({6'h00, {run, irq_n} & m}, {6'h00, e});
            @(posedge clk);
        end
    endtask
    // trailing edge keeps a following call from re-driving wr in one step
    task wr8(input logic [7:0] a, input logic [7:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd8(input logic [7:0] a, input logic [7:0] exp);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            chk(rdata, exp);
            @(posedge clk);
        end
    endtask
    task ev(input logic [7:0] l, input logic [6:0] d, input logic f);
        begin
            lo <= l;
            dev <= d;
            fly <= f;
            @(posedge clk);
            lo <= 8'h00;
            dev <= 7'h00;
            fly <= 1'b0;
            @(posedge clk);
        end
    endtask
    task waitirq(input logic lvl);
        integer n;
        begin
            n = 0;
            @(negedge clk);
            while (irq_n !== lvl && n < 20) begin
                @(negedge clk);
                n = n + 1;
            end
            chk({7'h00, irq_n}, {7'h00, lvl});
            if (n == 20) give_verdict;
            @(posedge clk);
        end
    endtask
    task t_reset;
        begin
            fl2(2'b01, 2'b11);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h00);
            rd8(`SDI_OFF_DMA_INT_STATUS, 8'h80);
            rd8(8'h3c, 8'h00);
            $display("reset test done");
        end
    endtask
    task t_dma;
        begin
            wr8(`SDI_OFF_DEN, 8'hff);
            wr8(`SDI_OFF_MODE, 8'h02);
            fl2(2'b11, 2'b11);
            ev(8'h00, 7'h01, 1'b0);
            waitirq(1'b0);
            fl2(2'b00, 2'b11);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h01);
            rd8(`SDI_OFF_DMA_INT_STATUS, 8'h81);
            waitirq(1'b1);
            rd8(`SDI_OFF_DMA_INT_STATUS, 8'h80);
            $display("dma test done");
        end
    endtask
    task t_masked;
        begin
            wr8(`SDI_OFF_MODE, 8'h02);
            ev(8'h02, 7'h00, 1'b0);
            repeat (4) @(posedge clk);
            fl2(2'b11, 2'b11);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h08);
            rd8(`SDI_OFF_SSTAT_LO, 8'h00);
            ev(8'h10, 7'h00, 1'b0);
            repeat (4) @(posedge clk);
            fl2(2'b01, 2'b11);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h02);
            rd8(`SDI_OFF_SSTAT_LO, 8'h12);
            rd8(`SDI_OFF_SSTAT_HI, 8'h00);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h00);
            $display("masked test done");
        end
    endtask
    task t_stack;
        begin
            wr8(`SDI_OFF_SEN_LO, 8'hff);
            wr8(`SDI_OFF_MODE, 8'h02);
            ev(8'h02, 7'h00, 1'b0);
            waitirq(1'b0);
            fl2(2'b00, 2'b11);
            ev(8'h20, 7'h00, 1'b0);
            rd8(`SDI_OFF_SSTAT_LO, 8'h02);
            rd8(`SDI_OFF_SSTAT_HI, 8'h00);
            repeat (8) @(posedge clk);
            waitirq(1'b0);
            rd8(`SDI_OFF_SSTAT_LO, 8'h20);
            rd8(`SDI_OFF_SSTAT_HI, 8'h00);
            waitirq(1'b1);
            $display("stack test done");
        end
    endtask
    task t_pin;
        begin
            wr8(`SDI_OFF_DCTL, 8'h02);
            ev(8'h00, 7'h02, 1'b0);
            repeat (5) @(posedge clk);
            fl2(2'b01, 2'b11);
            wr8(`SDI_OFF_DCTL, 8'h00);
            waitirq(1'b0);
            wr8(`SDI_OFF_DEN, 8'h00);
            repeat (4) @(posedge clk);
            fl2(2'b00, 2'b11);
            rd8(`SDI_OFF_DMA_INT_STATUS, 8'h82);
            waitirq(1'b1);
            $display("pin mask test done");
        end
    endtask
    task t_fly;
        begin
            wr8(`SDI_OFF_MODE, 8'h02);
            ev(8'h00, 7'h00, 1'b1);
            repeat (4) @(posedge clk);
            fl2(2'b10, 2'b10);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h0c);
            wr8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h00);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h0c);
            wr8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h04);
            rd8(`SDI_OFF_INTERRUPT_SUMMARY_STATUS, 8'h08);
            ack <= 1'b1;
            @(posedge clk);
            ack <= 1'b0;
            repeat (3) @(posedge clk);
            fl2(2'b01, 2'b11);
            $display("on-fly test done");
        end
    endtask
    task t_fifo;
        begin
            fill <= 1'b1;
            @(posedge clk);
            fill <= 1'b0;
            repeat (3) @(posedge clk);
            rd8(`SDI_OFF_DMA_INT_STATUS, 8'h00);
            ev(8'h40, 7'h00, 1'b0);
            repeat (6) @(posedge clk);
            fl2(2'b01, 2'b01);
            wr8(`SDI_OFF_CHIP_TEST_REG_THREE, 8'h04);
            wr8(`SDI_OFF_SCSI_TEST_REG_THREE, 8'h02);
            waitirq(1'b0);
            rd8(`SDI_OFF_SSTAT_LO, 8'h40);
            rd8(`SDI_OFF_SSTAT_HI, 8'h00);
            waitirq(1'b1);
            $display("fifo test done");
        end
    endtask
    // only the drain flush can empty the fifo here, else waitirq times out
    task t_drain;
        begin
            fill <= 1'b1;
            @(posedge clk);
            fill <= 1'b0;
            rx <= 1'b1;
            repeat (3) @(posedge clk);
            ev(8'h40, 7'h00, 1'b0);
            waitirq(1'b0);
            rd8(`SDI_OFF_SSTAT_LO, 8'h40);
            rx <= 1'b0;
            waitirq(1'b1);
            $display("drain test done");
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_dma;
        t_masked;
        t_stack;
        t_pin;
        t_fly;
        t_fifo;
        t_drain;
        give_verdict;
    end
endmodule
